/* psram_bus_pkg.sv */
// Constants and types shared by the DDR pseudo-static RAM bus port
package psram_bus_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 10;
	localparam int ACC_TIME_NS        = 40;   // Access time
	localparam int CLK_STOP_EXTRA_NS  = 30;   // Margin beyond access time
	localparam int CLK_STOP_CYC       = (ACC_TIME_NS + CLK_STOP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DPD_CSL_NS         = 200;  // Least select-low time to wake
	localparam int DPD_CSL_CYC        = (DPD_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DPD_OUT_US         = 150;  // Longest wake-up time
	localparam int DPD_OUT_CYC        = (DPD_OUT_US * 1000) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Framing and fields
	// ------------------------------------------------------------
	localparam int CA_BYTES           = 6;    // Command-address bytes
	localparam int CA_RW_BIT          = 47;   // 1 = read
	localparam int CA_REG_BIT         = 46;   // 1 = register space
	localparam int LAT_CLKS           = 6;    // Initial latency in clocks
	localparam int CNT_W              = 16;
	localparam int PD_CTRL_BIT        = 15;   // power_down_control_bit
	localparam logic [7:0] CR0_ADDR_HI = 8'h01; // Register address byte 4 selecting CR0

	// ------------------------------------------------------------
	// Bus states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_CMD_ADDR,
		ST_LAT_READ,
		ST_LAT_WRITE,
		ST_READ_DATA,
		ST_WRITE_DATA,
		ST_ZL_WRITE,
		ST_DEEP_PD
	} bus_state_t;

endpackage : psram_bus_pkg

/* edge_sync.sv */
// Two-flop synchroniser with edge detection for bus pins
`timescale 1ns/100ps
module edge_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] IDLE = '0   // Pin level while the bus is idle
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Pin in, synchronised level and edges out
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] last_r;

	// ------------------------------------------------------------
	// Synchroniser: first flop is read only by the second
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		// Start at the idle level so that leaving reset shows no false edge
		if (!arst_n) begin
			meta_r <= IDLE;
			sync_r <= IDLE;
			last_r <= IDLE;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// Edges come from the settled flops only
	assign level = sync_r;
	assign rise  = sync_r & ~last_r;
	assign fall  = ~sync_r & last_r;

endmodule : edge_sync

/* psram_bus_port.sv */
// Device side bus state machine of the DDR pseudo-static RAM
`timescale 1ns/100ps
// Contract
// - Read latency: strobe low, data released
// - Write latency: strobe and data released
// - Strobe always driven during command-address
// - Zero-latency write: strobe low or released
// - Zero-latency writes store every byte until deep power down is entered
// - Driven signals hold stable levels
// - Clearing power-down bit enters deep power down
// - Select pulse or reset exits power down
// - Clock parked low enters clock stop, read held
module psram_bus_port
	import psram_bus_pkg::*;
#(
	parameter int DPD_OUT_CYCLES = DPD_OUT_CYC,
	parameter bit EXTRA_LATENCY  = 1'b0
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Bus pins from the host
	input  wire logic        cs_n,
	input  wire logic        reset_n,
	input  wire logic        bus_clock_true,
	input  wire logic        bus_clock_complement,
	// Data lines
	input  wire logic [7:0]  dq_in,
	output logic      [7:0]  dq_out,
	output logic             dq_oe,
	// Strobe and mask line
	input  wire logic        strobe_mask_line_in,
	output logic             strobe_mask_line_out,
	output logic             strobe_mask_line_oe,
	// Array side
	output logic             wr_en,
	output logic      [7:0]  wr_data,
	output logic      [31:0] wr_addr,
	output logic             rd_en,
	output logic      [31:0] rd_addr,
	input  wire logic [7:0]  rd_data,
	// Status
	output logic             deep_power_down,
	output logic             clock_stopped
);
	import psram_bus_pkg::*;

	bus_state_t         state_r, state_nxt;
	logic [47:0]        ca_r;
	logic [CNT_W-1:0]   cnt_r;
	logic [CNT_W-1:0]   idle_r;
	logic [CNT_W-1:0]   wake_r;
	logic [31:0]        addr_r;
	logic [7:0]         dq_out_r;
	logic               dq_oe_r, rw_out_r, rw_oe_r;
	logic               wr_en_r, rd_en_r, dpd_r, stop_r;
	logic [7:0]         wr_data_r;
	logic [31:0]        wr_addr_r, rd_addr_r;
	logic               cs_lvl, cs_rise, cs_fall, rst_lvl;
	logic               ck_rise, ck_fall, ck_lvl, ckn_lvl, rw_lvl;
	logic [7:0]         dq_lvl;

	// Truncate a cycle count to the counter width
	function automatic logic [CNT_W-1:0] cyc(input int n);
		return CNT_W'(n);
	endfunction : cyc

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	edge_sync #(.W(1), .IDLE(1'b1)) u_cs (.clk(clk), .arst_n(arst_n), .pin(cs_n),
		.level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
	edge_sync #(.W(1), .IDLE(1'b1)) u_rst (.clk(clk), .arst_n(arst_n), .pin(reset_n),
		.level(rst_lvl), .rise(), .fall());
	edge_sync #(.W(1)) u_ck (.clk(clk), .arst_n(arst_n), .pin(bus_clock_true),
		.level(ck_lvl), .rise(ck_rise), .fall(ck_fall));
	edge_sync #(.W(1), .IDLE(1'b1)) u_ckn (.clk(clk), .arst_n(arst_n), .pin(bus_clock_complement),
		.level(ckn_lvl), .rise(), .fall());
	edge_sync #(.W(1)) u_rw (.clk(clk), .arst_n(arst_n), .pin(strobe_mask_line_in),
		.level(rw_lvl), .rise(), .fall());
	edge_sync #(.W(8)) u_dq (.clk(clk), .arst_n(arst_n), .pin(dq_in),
		.level(dq_lvl), .rise(), .fall());

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire ck_edge   = ck_rise | ck_fall;           // DDR: one byte per edge
	wire selected  = ~cs_lvl;
	wire is_reg    = ca_r[CA_REG_BIT];
	wire ca_done   = ck_edge && cnt_r == cyc(CA_BYTES - 1);
	wire lat_done  = ck_edge && cnt_r == cyc(2 * LAT_CLKS * (EXTRA_LATENCY ? 2 : 1) - 1);
	wire [47:0] ca_full = {ca_r[39:0], dq_lvl};
	wire pd_write  = is_reg && ca_r[15:8] == CR0_ADDR_HI && cnt_r == '0 && ck_edge
		&& !dq_lvl[PD_CTRL_BIT-8];                  // High byte first
	wire wake_ok   = cs_rise && wake_r >= cyc(DPD_CSL_CYC);
	wire mask_ok   = state_r == ST_ZL_WRITE || !rw_lvl;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_STANDBY:    if (cs_fall) state_nxt = ST_CMD_ADDR;
			ST_CMD_ADDR:   if (ca_done) state_nxt = ca_full[CA_RW_BIT] ? ST_LAT_READ :
				ca_full[CA_REG_BIT] ? ST_ZL_WRITE : ST_LAT_WRITE;
			ST_LAT_READ:   if (lat_done) state_nxt = ST_READ_DATA;
			ST_LAT_WRITE:  if (lat_done) state_nxt = ST_WRITE_DATA;
			ST_READ_DATA:  state_nxt = state_r;
			ST_WRITE_DATA: state_nxt = state_r;
			ST_ZL_WRITE:   if (pd_write) state_nxt = ST_DEEP_PD;
			ST_DEEP_PD:    if (wake_ok || wake_r == cyc(1)) state_nxt = ST_DEEP_PD;
		endcase
		if (state_r != ST_DEEP_PD && state_r != ST_ZL_WRITE && !selected)
			state_nxt = ST_STANDBY;
		if (state_r == ST_DEEP_PD && wake_ok)
			state_nxt = ST_STANDBY;
		if (!rst_lvl)
			state_nxt = ST_STANDBY;
	end

	// ------------------------------------------------------------
	// State, counters and capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_STANDBY;
			cnt_r   <= '0;
			ca_r    <= '0;
			addr_r  <= '0;
			wake_r  <= '0;
		end else begin
			state_r <= (state_r == ST_ZL_WRITE && !selected && !pd_write) ? ST_STANDBY : state_nxt;
			if (state_nxt != state_r)
				cnt_r <= '0;
			else if (ck_edge)
				cnt_r <= cnt_r + 1'b1;
			if (state_r == ST_CMD_ADDR && ck_edge)
				ca_r <= ca_full;
			if (state_r == ST_CMD_ADDR && ca_done)
				addr_r <= {ca_full[36:8], ca_full[2:0]};
			else if ((state_r == ST_READ_DATA || state_r == ST_WRITE_DATA || state_r == ST_ZL_WRITE) && ck_edge)
				addr_r <= addr_r + 1'b1;
			wake_r <= (state_r == ST_DEEP_PD && selected) ? wake_r + 1'b1 : '0;
		end
	end

	// ------------------------------------------------------------
	// Clock stop detection: no bus clock edge for the limit
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_r <= '0;
			stop_r <= 1'b0;
		end else begin
			idle_r <= (ck_edge || !selected) ? '0 : (idle_r == cyc(CLK_STOP_CYC) ? idle_r : idle_r + 1'b1);
			stop_r <= selected && !ck_edge && idle_r >= cyc(CLK_STOP_CYC - 1) && !ck_lvl && ckn_lvl;
		end
	end

	// ------------------------------------------------------------
	// Pin drive: owner per bus state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_out_r <= 8'h00;
			dq_oe_r  <= 1'b0;
			rw_out_r <= 1'b0;
			rw_oe_r  <= 1'b0;
		end else begin
			unique case (state_nxt)
				ST_CMD_ADDR:   begin dq_oe_r <= 1'b0; rw_oe_r <= 1'b1; rw_out_r <= EXTRA_LATENCY; end
				ST_LAT_READ:   begin dq_oe_r <= 1'b0; rw_oe_r <= 1'b1; rw_out_r <= 1'b0; end
				ST_LAT_WRITE:  begin dq_oe_r <= 1'b0; rw_oe_r <= 1'b0; end
				ST_READ_DATA:  begin dq_oe_r <= 1'b1; rw_oe_r <= 1'b1; end
				ST_ZL_WRITE:   begin dq_oe_r <= 1'b0; rw_oe_r <= 1'b1; rw_out_r <= 1'b0; end
				ST_STANDBY, ST_WRITE_DATA, ST_DEEP_PD: begin
					dq_oe_r  <= 1'b0;
					rw_oe_r  <= 1'b0;
					rw_out_r <= 1'b0;
				end
			endcase
			// Read data held while the clock is stopped
			if (state_r == ST_READ_DATA && ck_edge) begin
				dq_out_r <= rd_data;
				rw_out_r <= ck_rise;                     // Strobe follows clock
			end
		end
	end

	// ------------------------------------------------------------
	// Array strobes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_en_r   <= 1'b0;
			wr_data_r <= 8'h00;
			wr_addr_r <= '0;
			rd_en_r   <= 1'b0;
			rd_addr_r <= '0;
			dpd_r     <= 1'b0;
		end else begin
			wr_en_r   <= (state_r == ST_WRITE_DATA || state_r == ST_ZL_WRITE) && ck_edge && mask_ok;
			wr_data_r <= dq_lvl;
			wr_addr_r <= addr_r;
			rd_en_r   <= state_r == ST_READ_DATA && ck_edge;
			rd_addr_r <= addr_r;
			dpd_r     <= state_nxt == ST_DEEP_PD;
		end
	end

	assign dq_out               = dq_out_r;
	assign dq_oe                = dq_oe_r;
	assign strobe_mask_line_out = rw_out_r;
	assign strobe_mask_line_oe  = rw_oe_r;
	assign wr_en                = wr_en_r;
	assign wr_data              = wr_data_r;
	assign wr_addr              = wr_addr_r;
	assign rd_en                = rd_en_r;
	assign rd_addr              = rd_addr_r;
	assign deep_power_down      = dpd_r;
	assign clock_stopped        = stop_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_READ_LAT: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_LAT_READ && $past(state_r) == ST_LAT_READ |-> rw_oe_r && !rw_out_r && !dq_oe_r)
		else $error("read latency drive wrong");
	AST_WRITE_LAT: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_LAT_WRITE |-> !dq_oe_r && !rw_oe_r)
		else $error("write latency drive wrong");
	AST_CA_STROBE: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_CMD_ADDR |-> rw_oe_r)
		else $error("strobe not driven in command phase");
	AST_ZL_LOW: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_ZL_WRITE && $past(state_r) == ST_ZL_WRITE |-> !rw_out_r && !dq_oe_r)
		else $error("zero latency strobe not low");
	AST_ZL_NOMASK: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_ZL_WRITE && ck_edge |=> wr_en_r)
		else $error("zero latency byte dropped");
	AST_IDLE_REL: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_STANDBY ##1 state_r == ST_STANDBY |-> !dq_oe_r && !rw_oe_r)
		else $error("bus driven in standby");
	AST_DPD_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_ZL_WRITE && pd_write |=> state_r == ST_DEEP_PD ##0 dpd_r)
		else $error("deep power down not entered");
	AST_DPD_EXIT: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_DEEP_PD && wake_ok |=> state_r == ST_STANDBY)
		else $error("deep power down not left");
	AST_STOP_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		state_r == ST_READ_DATA && !ck_edge |=> $stable(dq_out_r))
		else $error("read data moved without clock");
	COV_READ: cover property (@(posedge clk) disable iff (!arst_n) state_r == ST_READ_DATA);
	COV_WRITE: cover property (@(posedge clk) disable iff (!arst_n) state_r == ST_WRITE_DATA);
	COV_DPD: cover property (@(posedge clk) disable iff (!arst_n) state_r == ST_DEEP_PD ##1 state_r == ST_STANDBY);
	COV_STOP: cover property (@(posedge clk) disable iff (!arst_n) stop_r);

endmodule : psram_bus_port

/* psram_host_model.sv */
// Host controller model that drives the bus pins of the pseudo-static RAM port
`timescale 1ns/100ps
module psram_host_model (
	// Clock
	input  wire logic       clk,
	// Pins towards the device
	output logic            cs_n,
	output logic            reset_n,
	output logic            bus_clock_true,
	output logic            bus_clock_complement,
	output logic      [7:0] dq_in,
	output logic            strobe_mask_line_in,
	// Device drive of the shared lines
	input  wire logic [7:0] dq_out,
	input  wire logic       dq_oe,
	input  wire logic       strobe_mask_line_out,
	input  wire logic       strobe_mask_line_oe
);
	logic [7:0] dq_h;
	logic       dq_he;
	logic       rw_h;
	logic       rw_he;
	logic [7:0] dq_last;
	logic       rw_last;
	int         half_cnt;

	// ------------------------------------------------------------
	// Wire resolution
	// ------------------------------------------------------------
	// A released line flips every cycle so that no stale level can pass for data
	assign dq_in               = dq_oe ? dq_out : (dq_he ? dq_h : ~dq_last);
	assign strobe_mask_line_in = strobe_mask_line_oe ? strobe_mask_line_out : (rw_he ? rw_h : ~rw_last);
	always @(posedge clk) begin
		dq_last <= dq_in;
		rw_last <= strobe_mask_line_in;
	end

	// Clock parked idle, bus released, not selected
	initial begin
		cs_n = 1'b1;
		reset_n = 1'b1;
		bus_clock_true = 1'b0;
		bus_clock_complement = 1'b1;
		dq_h = 8'h00;
		dq_he = 1'b0;
		rw_h = 1'b0;
		rw_he = 1'b0;
		dq_last = 8'h00;
		rw_last = 1'b0;
		half_cnt = 0;
	end

	// ------------------------------------------------------------
	// Bus tasks, entered just after a falling clk edge
	// ------------------------------------------------------------
	task automatic select();
		cs_n = 1'b0;
		repeat (3) @(negedge clk);
	endtask : select

	// Ends the transfer well inside the select-low limit, clock already parked low
	task automatic deselect();
		cs_n = 1'b1;
		dq_he = 1'b0;
		rw_he = 1'b0;
		repeat (2) @(negedge clk);
	endtask : deselect

	// One half period; a 6,6,6,7 cycle pattern averages 125 ns per bus clock period
	task automatic bus_edge(input logic [7:0] d, input logic de, input logic m, input logic me);
		dq_h = d;
		dq_he = de;
		rw_h = m;
		rw_he = me;
		repeat (3) @(negedge clk);
		bus_clock_true = ~bus_clock_true;
		bus_clock_complement = ~bus_clock_true;
		repeat ((half_cnt % 4 == 3) ? 4 : 3) @(negedge clk);
		half_cnt++;
	endtask : bus_edge

	// Dummy select pulse with the bus clock parked, used to leave deep power down
	task automatic pulse_cs(input int cycles);
		cs_n = 1'b0;
		repeat (cycles) @(negedge clk);
		cs_n = 1'b1;
	endtask : pulse_cs

	// Hardware reset pulse on the reset pin
	task automatic pulse_reset(input int cycles);
		reset_n = 1'b0;
		repeat (cycles) @(negedge clk);
		reset_n = 1'b1;
	endtask : pulse_reset
endmodule : psram_host_model

/* tb_top.sv */
// Self-checking testbench of the pseudo-static RAM bus port
`timescale 1ns/100ps
module tb_top;
	import psram_bus_pkg::*;
	localparam int WAKE_CYC = 10;
	logic        clk;
	logic        arst_n;
	logic        cs_n;
	logic        reset_n;
	logic        ck_t;
	logic        ck_c;
	logic [7:0]  dq_in;
	logic [7:0]  dq_out;
	logic        dq_oe;
	logic        rw_in;
	logic        rw_out;
	logic        rw_oe;
	logic        wr_en;
	logic [7:0]  wr_data;
	logic [31:0] wr_addr;
	logic        rd_en;
	logic [31:0] rd_addr;
	logic [7:0]  rd_data;
	logic        deep_power_down;
	logic        clock_stopped;
	int          failures = 0;
	int          samples_checked = 0;
	int          wr_count = 0;
	logic [7:0]  wr_last;
	logic [31:0] wr_addr_last;
	logic [31:0] rd_first;
	logic        rd_seen;

	// ------------------------------------------------------------
	// Clock, array stand-in, device and host
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	assign rd_data = rd_addr[7:0] ^ 8'hC3;
	// Count array writes and note the first read address of a burst
	always @(posedge clk) begin
		if (wr_en === 1'b1) begin
			wr_count <= wr_count + 1;
			wr_last  <= wr_data;
			wr_addr_last <= wr_addr;
		end
		if (rd_en === 1'b1 && rd_seen === 1'b0) begin
			rd_first <= rd_addr;
			rd_seen  <= 1'b1;
		end
	end
	psram_bus_port #(.DPD_OUT_CYCLES(WAKE_CYC), .EXTRA_LATENCY(1'b0)) u_dut (
		.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .reset_n(reset_n), .bus_clock_true(ck_t),
		.bus_clock_complement(ck_c), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.strobe_mask_line_in(rw_in), .strobe_mask_line_out(rw_out), .strobe_mask_line_oe(rw_oe),
		.wr_en(wr_en), .wr_data(wr_data), .wr_addr(wr_addr), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data), .deep_power_down(deep_power_down), .clock_stopped(clock_stopped));
	psram_host_model u_host (
		.clk(clk), .cs_n(cs_n), .reset_n(reset_n), .bus_clock_true(ck_t), .bus_clock_complement(ck_c),
		.dq_in(dq_in), .strobe_mask_line_in(rw_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.strobe_mask_line_out(rw_out), .strobe_mask_line_oe(rw_oe));

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Read of address 0; optionally stalls the bus clock in the data phase
	task automatic t_read(input bit stall);
		rd_seen = 1'b0;
		u_host.select();
		for (int e = 1; e <= 22; e++) begin
			u_host.bus_edge((e == 1) ? 8'h80 : 8'h00, e <= 6, 1'b0, 1'b0);
			if (e == 3) check("ca strobe", 32'({rw_oe, rw_out}), 32'({1'b1, 1'b0}));
			if (e == 10) check("read latency", 32'({rw_oe, rw_out, dq_oe}), 32'(3'b100));
			if (e == 20) check("read drive", 32'({dq_oe, rw_oe}), 32'(2'b11));
			if (e == 20) check("read addr", rd_first, 32'h0);
			// Second data byte comes from address 1 of the array stand-in
			if (e == 20) check("read data", 32'(dq_out), 32'(8'hC3 ^ 8'h01));
			// Clock parked low after an even edge count, long enough to pass the stop time
			if (e == 20 && stall) begin
				repeat (CLK_STOP_CYC + 8) @(negedge clk);
				check("clock stop", 32'(clock_stopped), 32'(1));
				check("stop data", 32'(dq_oe), 32'(1));
			end
		end
		u_host.deselect();
		repeat (6) @(negedge clk);
		check("idle release", 32'({dq_oe, rw_oe}), 32'(0));
	endtask : t_read

	// Memory write with latency, second of four bytes masked
	task automatic t_write();
		int base;
		base = wr_count;
		u_host.select();
		for (int e = 1; e <= 22; e++) begin
			u_host.bus_edge(8'(e * 17), e <= 6 || e > 18, e == 20, e > 18);
			if (e == 10) check("write latency", 32'({rw_oe, dq_oe}), 32'(0));
		end
		u_host.deselect();
		repeat (6) @(negedge clk);
		check("write count", 32'(wr_count - base), 32'(3));
		check("write byte", 32'(wr_last), 32'(8'(22 * 17)));
		// Address from command bits 36:8 and 2:0, plus three bytes on
		check("write addr", wr_addr_last, 32'h119A22B1);
	endtask : t_write

	// Zero-latency register write clearing the power-down control bit
	task automatic enter_pd();
		u_host.select();
		for (int e = 1; e <= 8; e++) begin
			u_host.bus_edge((e == 1) ? 8'h40 : (e == 5) ? 8'h01 : (e == 7) ? 8'h7F : 8'hFF, 1'b1, 1'b0, 1'b0);
			if (e == 3) check("zl ca strobe", 32'(rw_oe), 32'(1));
			if (e == 7) check("zl strobe", 32'(rw_oe & rw_out), 32'(0));
		end
		u_host.deselect();
		repeat (6) @(negedge clk);
		check("pd entered", 32'(deep_power_down), 32'(1));
		check("pd release", 32'({dq_oe, rw_oe}), 32'(0));
	endtask : enter_pd

	// Short select pulse ignored, long one wakes; then wake by the reset pin
	task automatic t_power_down();
		enter_pd();
		u_host.pulse_cs(10);
		repeat (30) @(negedge clk);
		check("short pulse", 32'(deep_power_down), 32'(1));
		u_host.pulse_cs(25);
		repeat (WAKE_CYC + 10) @(negedge clk);
		check("pulse wake", 32'(deep_power_down), 32'(0));
		enter_pd();
		u_host.pulse_reset(5);
		repeat (WAKE_CYC + 10) @(negedge clk);
		check("reset wake", 32'(deep_power_down), 32'(0));
	endtask : t_power_down

	// Main sequence
	initial begin
		arst_n = 1'b0;
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		check("reset release", 32'({dq_oe, rw_oe, deep_power_down}), 32'(0));
		t_read(1'b0);
		t_read(1'b1);
		t_write();
		t_power_down();
		give_verdict();
	end

	// Watchdog, over twenty times the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule : tb_top
